// >>> logic/recp_pkg.sv
// Purpose: shared constants and carriers for the receive error counter and pcs config block
// Assumes: 16-bit register data over a plain strobe port
// Notes: offsets are register indexes on the management port
package recp_pkg;
    localparam logic [4:0] RECP_ADDR_ERR_CNT = 5'h15;
    localparam logic [4:0] RECP_ADDR_PCS_CFG = 5'h16;
    localparam logic [15:0] RECP_ERR_CNT_RST = 16'h0000;
    localparam logic [7:0] RECP_TALLY_MAX = 8'hff;
    localparam logic [3:0] RECP_PCS_RST = 4'h1;
    localparam int RECP_BIT_FREE_CLK = 11;
    localparam int RECP_BIT_SILENT = 10;
    localparam int RECP_BIT_FORCE_SD = 9;
    localparam int RECP_BIT_HOLD = 8;
    localparam int RECP_CFG_LO = 8;
    localparam int RECP_CFG_HI = 11;

    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } recp_req_t;

    typedef struct packed {
        logic carrier;
        logic bad_symbol;
        logic collision;
        logic signal_valid;
        logic descr_lock;
    } recp_line_t;

    typedef struct packed {
        logic rx_clk_free_run;
        logic tx_silent_mode_enable;
        logic force_signal_detect;
        logic link_hold_policy;
    } recp_cfg_t;
endpackage : recp_pkg

// >>> logic/recp_regs.sv
// Purpose: receive symbol error count and upper pcs configuration bits
// Assumes: all line status inputs synchronous to core_clk
// Notes: read data valid the cycle after the read strobe
// Function
// RULE_01 - error count upper byte ignores writes, reads zero, resets zero
// RULE_02 - count increments when carrier valid and an invalid symbol seen
// RULE_03 - at most one increment per carrier event
// RULE_04 - no increment for a carrier event with collision
// RULE_05 - count saturates at maximum, never wraps
// RULE_06 - read returns count then clears it; reset clears it
// RULE_07 - software keeps pcs reserved bits 15:12 at zero
// RULE_08 - bit 11 set gives free running rx clock, else phase aligned
// RULE_09 - bit 10 set selects transmit true quiet mode
// RULE_10 - bit 9 set forces signal detect in the pma
// RULE_11 - link rises only after valid signal and descrambler lock
// RULE_12 - bit 8 high: link holds while signal valid, lock loss ignored
// RULE_13 - bit 8 low: link holds only while signal valid and locked
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module recp_regs (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire recp_pkg::recp_req_t req,
    output logic [15:0] rdata,
    input wire recp_pkg::recp_line_t line,
    output recp_pkg::recp_cfg_t cfg,
    output logic signal_detect,
    output logic link_up
);
    import recp_pkg::*;

    logic [7:0] symbol_error_tally_r;
    logic [3:0] cfg_r;
    logic [15:0] rdata_r;
    logic event_bad_r;
    logic event_coll_r;
    logic carrier_d_r;
    logic link_r;

    ////////////////////////////////////////////////////////////////////
    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        hit = (a == off);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////
    // event tracking: one verdict per carrier event, judged at its end
    wire logic event_end = carrier_d_r & ~line.carrier;
    wire logic count_evt = event_end & event_bad_r & ~event_coll_r;
    wire logic rd_cnt = req.rd & hit(req.addr, RECP_ADDR_ERR_CNT);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            carrier_d_r <= 1'b0;
            event_bad_r <= 1'b0;
            event_coll_r <= 1'b0;
        end else begin
            carrier_d_r <= line.carrier;
            if (line.carrier) begin
                event_bad_r <= (carrier_d_r ? event_bad_r : 1'b0) | line.bad_symbol; // RULE_02
                event_coll_r <= (carrier_d_r ? event_coll_r : 1'b0) | line.collision; // RULE_04
            end else begin
                event_bad_r <= 1'b0;
                event_coll_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // an event landing with the clearing read survives as a count of one
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            symbol_error_tally_r <= RECP_ERR_CNT_RST[7:0]; // RULE_06
        end else if (rd_cnt) begin
            symbol_error_tally_r <= {7'h00, count_evt}; // RULE_06
        end else if (count_evt && symbol_error_tally_r != RECP_TALLY_MAX) begin
            symbol_error_tally_r <= symbol_error_tally_r + 8'h01; // RULE_03 RULE_05
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reserved upper bits are not stored; software keeps them zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cfg_r <= RECP_PCS_RST;
        end else if (req.wr && hit(req.addr, RECP_ADDR_PCS_CFG)) begin
            cfg_r <= req.wdata[RECP_CFG_HI:RECP_CFG_LO]; // RULE_07
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_r <= 16'h0000;
        end else if (req.rd) begin
            case (1'b1)
                hit(req.addr, RECP_ADDR_ERR_CNT): rdata_r <= {8'h00, symbol_error_tally_r}; // RULE_01
                hit(req.addr, RECP_ADDR_PCS_CFG): rdata_r <= {4'h0, cfg_r, 8'h00};
                default: rdata_r <= 16'h0000;
            endcase
        end else begin
            rdata_r <= 16'h0000;
        end
    end
    assign rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////
    assign cfg.rx_clk_free_run = cfg_r[RECP_BIT_FREE_CLK - RECP_CFG_LO]; // RULE_08
    assign cfg.tx_silent_mode_enable = cfg_r[RECP_BIT_SILENT - RECP_CFG_LO]; // RULE_09
    assign cfg.force_signal_detect = cfg_r[RECP_BIT_FORCE_SD - RECP_CFG_LO]; // RULE_10
    assign cfg.link_hold_policy = cfg_r[RECP_BIT_HOLD - RECP_CFG_LO];
    assign signal_detect = line.signal_valid | cfg_r[RECP_BIT_FORCE_SD - RECP_CFG_LO]; // RULE_10

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            link_r <= 1'b0;
        end else if (!link_r) begin
            link_r <= signal_detect & line.descr_lock; // RULE_11
        end else if (cfg_r[RECP_BIT_HOLD - RECP_CFG_LO]) begin
            link_r <= signal_detect; // RULE_12
        end else begin
            link_r <= signal_detect & line.descr_lock; // RULE_13
        end
    end
    assign link_up = link_r;

    ////////////////////////////////////////////////////////////////////
    property p_upper_zero;
        @(posedge core_clk) disable iff (sys_rst)
        $past(rd_cnt) |-> rdata[15:8] == 8'h00;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("count upper byte not zero"); // RULE_01

    property p_count_up;
        @(posedge core_clk) disable iff (sys_rst)
        count_evt && !rd_cnt && symbol_error_tally_r != 8'hff
            |=> symbol_error_tally_r == $past(symbol_error_tally_r) + 8'h01;
    endproperty
    a_count_up: assert property (p_count_up) else $error("error count did not advance"); // RULE_02

    property p_once;
        @(posedge core_clk) disable iff (sys_rst)
        !rd_cnt && !event_end |=> symbol_error_tally_r == $past(symbol_error_tally_r);
    endproperty
    a_once: assert property (p_once) else $error("count moved mid event"); // RULE_03

    property p_coll;
        @(posedge core_clk) disable iff (sys_rst)
        event_end && event_coll_r && !rd_cnt |=> $stable(symbol_error_tally_r);
    endproperty
    a_coll: assert property (p_coll) else $error("collision event counted"); // RULE_04

    property p_sat;
        @(posedge core_clk) disable iff (sys_rst)
        symbol_error_tally_r == 8'hff && !rd_cnt |=> symbol_error_tally_r == 8'hff;
    endproperty
    a_sat: assert property (p_sat) else $error("count wrapped"); // RULE_05

    property p_clr;
        @(posedge core_clk) disable iff (sys_rst)
        rd_cnt |=> rdata[7:0] == $past(symbol_error_tally_r) && symbol_error_tally_r <= 8'h01;
    endproperty
    a_clr: assert property (p_clr) else $error("read did not return and clear"); // RULE_06

    property p_free;
        @(posedge core_clk) disable iff (sys_rst)
        req.wr && hit(req.addr, RECP_ADDR_PCS_CFG)
            |=> cfg.rx_clk_free_run == $past(req.wdata[RECP_BIT_FREE_CLK]);
    endproperty
    a_free: assert property (p_free) else $error("free clock bit wrong"); // RULE_08

    property p_silent;
        @(posedge core_clk) disable iff (sys_rst)
        req.wr && hit(req.addr, RECP_ADDR_PCS_CFG)
            |=> cfg.tx_silent_mode_enable == $past(req.wdata[RECP_BIT_SILENT]);
    endproperty
    a_silent: assert property (p_silent) else $error("quiet mode bit wrong"); // RULE_09

    property p_force;
        @(posedge core_clk) disable iff (sys_rst)
        cfg.force_signal_detect |-> signal_detect;
    endproperty
    a_force: assert property (p_force) else $error("forced detect missing"); // RULE_10

    property p_rise;
        @(posedge core_clk) disable iff (sys_rst)
        $rose(link_up) |-> $past(signal_detect) && $past(line.descr_lock);
    endproperty
    a_rise: assert property (p_rise) else $error("link rose without lock"); // RULE_11

    property p_hold;
        @(posedge core_clk) disable iff (sys_rst)
        link_up && cfg.link_hold_policy && signal_detect |=> link_up;
    endproperty
    a_hold: assert property (p_hold) else $error("link dropped on lock loss"); // RULE_12

    property p_strict;
        @(posedge core_clk) disable iff (sys_rst)
        link_up && !cfg.link_hold_policy && !line.descr_lock |=> !link_up;
    endproperty
    a_strict: assert property (p_strict) else $error("link held without lock"); // RULE_13

    ////////////////////////////////////////////////////////////////////
    // counter side: writes, read word and event bookkeeping
    property p_wr_cnt_ignored;
        @(posedge core_clk) disable iff (sys_rst)
        req.wr && hit(req.addr, RECP_ADDR_ERR_CNT) && !count_evt |=> $stable(symbol_error_tally_r);
    endproperty
    a_wr_cnt_ignored: assert property (p_wr_cnt_ignored) else $error("count took a write"); // RULE_01

    property p_rdata_idle;
        @(posedge core_clk) disable iff (sys_rst)
        !$past(req.rd) |-> rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot"); // RULE_06

    property p_bad_needed;
        @(posedge core_clk) disable iff (sys_rst)
        event_end && !event_bad_r && !rd_cnt |=> $stable(symbol_error_tally_r);
    endproperty
    a_bad_needed: assert property (p_bad_needed) else $error("clean event counted"); // RULE_02

    property p_bad_tracks;
        @(posedge core_clk) disable iff (sys_rst)
        line.carrier && line.bad_symbol |=> event_bad_r;
    endproperty
    a_bad_tracks: assert property (p_bad_tracks) else $error("bad symbol not noted"); // RULE_02

    property p_bad_fresh;
        @(posedge core_clk) disable iff (sys_rst)
        line.carrier && !carrier_d_r && !line.bad_symbol |=> !event_bad_r;
    endproperty
    a_bad_fresh: assert property (p_bad_fresh) else $error("stale bad mark"); // RULE_03

    property p_idle_clear;
        @(posedge core_clk) disable iff (sys_rst)
        !line.carrier |=> !event_bad_r && !event_coll_r;
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("event marks kept"); // RULE_03

    property p_step_one;
        @(posedge core_clk) disable iff (sys_rst)
        !rd_cnt |=> symbol_error_tally_r == $past(symbol_error_tally_r)
            || symbol_error_tally_r == $past(symbol_error_tally_r) + 8'h01;
    endproperty
    a_step_one: assert property (p_step_one) else $error("count jumped"); // RULE_03

    property p_coll_tracks;
        @(posedge core_clk) disable iff (sys_rst)
        line.carrier && line.collision |=> event_coll_r;
    endproperty
    a_coll_tracks: assert property (p_coll_tracks) else $error("collision not noted"); // RULE_04

    property p_coll_blocks;
        @(posedge core_clk) disable iff (sys_rst)
        event_coll_r |-> !count_evt;
    endproperty
    a_coll_blocks: assert property (p_coll_blocks) else $error("collision event judged"); // RULE_04

    property p_sat_hold;
        @(posedge core_clk) disable iff (sys_rst)
        count_evt && symbol_error_tally_r == RECP_TALLY_MAX && !rd_cnt
            |=> symbol_error_tally_r == RECP_TALLY_MAX;
    endproperty
    a_sat_hold: assert property (p_sat_hold) else $error("count left maximum"); // RULE_05

    property p_no_wrap;
        @(posedge core_clk) disable iff (sys_rst)
        symbol_error_tally_r == RECP_TALLY_MAX && !rd_cnt |=> symbol_error_tally_r != 8'h00;
    endproperty
    a_no_wrap: assert property (p_no_wrap) else $error("count wrapped to zero"); // RULE_05

    property p_clr_plain;
        @(posedge core_clk) disable iff (sys_rst)
        rd_cnt && !count_evt |=> symbol_error_tally_r == 8'h00;
    endproperty
    a_clr_plain: assert property (p_clr_plain) else $error("read did not clear"); // RULE_06

    property p_clr_race;
        @(posedge core_clk) disable iff (sys_rst)
        rd_cnt && count_evt |=> symbol_error_tally_r == 8'h01;
    endproperty
    a_clr_race: assert property (p_clr_race) else $error("event lost on clear"); // RULE_06

    ////////////////////////////////////////////////////////////////////
    // config side and link
    property p_rd_cfg;
        @(posedge core_clk) disable iff (sys_rst)
        req.rd && hit(req.addr, RECP_ADDR_PCS_CFG) |=> rdata == {4'h0, $past(cfg_r), 8'h00};
    endproperty
    a_rd_cfg: assert property (p_rd_cfg) else $error("config read word wrong"); // RULE_07

    property p_reserved_zero;
        @(posedge core_clk) disable iff (sys_rst)
        req.rd && hit(req.addr, RECP_ADDR_PCS_CFG) |=> rdata[15:12] == 4'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // RULE_07

    property p_rd_unmapped;
        @(posedge core_clk) disable iff (sys_rst)
        req.rd && !hit(req.addr, RECP_ADDR_ERR_CNT) && !hit(req.addr, RECP_ADDR_PCS_CFG)
            |=> rdata == 16'h0000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero"); // RULE_01

    property p_cfg_hold;
        @(posedge core_clk) disable iff (sys_rst)
        !(req.wr && hit(req.addr, RECP_ADDR_PCS_CFG)) |=> $stable(cfg_r);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed unasked"); // RULE_08

    property p_force_write;
        @(posedge core_clk) disable iff (sys_rst)
        req.wr && hit(req.addr, RECP_ADDR_PCS_CFG)
            |=> cfg.force_signal_detect == $past(req.wdata[RECP_BIT_FORCE_SD]);
    endproperty
    a_force_write: assert property (p_force_write) else $error("force bit wrong"); // RULE_10

    property p_hold_write;
        @(posedge core_clk) disable iff (sys_rst)
        req.wr && hit(req.addr, RECP_ADDR_PCS_CFG)
            |=> cfg.link_hold_policy == $past(req.wdata[RECP_BIT_HOLD]);
    endproperty
    a_hold_write: assert property (p_hold_write) else $error("hold policy bit wrong"); // RULE_12

    property p_sd_normal;
        @(posedge core_clk) disable iff (sys_rst)
        !cfg.force_signal_detect |-> signal_detect == line.signal_valid;
    endproperty
    a_sd_normal: assert property (p_sd_normal) else $error("detect not following line"); // RULE_10

    property p_link_needs_both;
        @(posedge core_clk) disable iff (sys_rst)
        !link_up && !(signal_detect && line.descr_lock) |=> !link_up;
    endproperty
    a_link_needs_both: assert property (p_link_needs_both) else $error("link rose early"); // RULE_11

    property p_link_rise;
        @(posedge core_clk) disable iff (sys_rst)
        !link_up && signal_detect && line.descr_lock |=> link_up;
    endproperty
    a_link_rise: assert property (p_link_rise) else $error("link failed to rise"); // RULE_11

    property p_drop_signal;
        @(posedge core_clk) disable iff (sys_rst)
        link_up && !signal_detect |=> !link_up;
    endproperty
    a_drop_signal: assert property (p_drop_signal) else $error("link held without signal"); // RULE_12

    property p_strict_hold;
        @(posedge core_clk) disable iff (sys_rst)
        link_up && !cfg.link_hold_policy && signal_detect && line.descr_lock |=> link_up;
    endproperty
    a_strict_hold: assert property (p_strict_hold) else $error("strict link dropped"); // RULE_13
endmodule : recp_regs
`default_nettype wire

// >>> bench/tb_recp_regs.sv
// Purpose: self-checking bench for the error count and pcs config registers
// Assumes: strobe bus, read data stands only in the cycle after the read strobe
// Notes: a monitor checks each read word against the oldest queued expectation
`timescale 1ns/1ps
`default_nettype none
module tb_recp_regs;
    import recp_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    recp_req_t req = '0;
    recp_line_t line = '0;
    logic [15:0] rdata;
    recp_cfg_t cfg;
    logic signal_detect, link_up;
    logic rd_d = 1'b0;
    logic [15:0] exp_q[$];
    logic [31:0] seed = 32'h5d5a;
    int num_errors = 0;
    int samples_checked = 0;
    int i;

    recp_regs recp_regs_inst (.core_clk(core_clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
        .line(line), .cfg(cfg), .signal_detect(signal_detect), .link_up(link_up));

    always #10 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one strobe cycle, then idle, so no strobe is driven twice in one step
    task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge core_clk);
        req <= '0;
    endtask : bus

    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 16'h0000);
    endtask : rd

    // carrier event: nbad bad cycles, then one clean cycle, then carrier low
    task automatic evt(input int nbad, input logic col);
        @(posedge core_clk);
        line.carrier <= 1'b1;
        line.collision <= col;
        for (int k = 0; k < nbad; k++) begin
            line.bad_symbol <= 1'b1;
            @(posedge core_clk);
        end
        line.bad_symbol <= 1'b0;
        @(posedge core_clk);
        line.carrier <= 1'b0;
        line.collision <= 1'b0;
        @(posedge core_clk);
    endtask : evt

    task automatic lk(input logic sv, input logic lock, input logic sd, input logic up);
        @(posedge core_clk);
        line.signal_valid <= sv;
        line.descr_lock <= lock;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk({14'h0000, signal_detect, link_up}, {14'h0000, sd, up});
    endtask : lk

    task automatic close_out();
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        rd_d <= req.rd;
        if (rd_d) begin
            chk(rdata, exp_q.pop_front());
        end
    end

    initial begin
        #200000;
        num_errors++;
        close_out();
    end

    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(RECP_ADDR_ERR_CNT, RECP_ERR_CNT_RST);
        rd(RECP_ADDR_PCS_CFG, {4'h0, RECP_PCS_RST, 8'h00});
        bus(1'b1, RECP_ADDR_ERR_CNT, 16'hffff);
        evt(3, 1'b0);
        evt(2, 1'b1);
        evt(0, 1'b0);
        rd(RECP_ADDR_ERR_CNT, 16'h0001);
        rd(RECP_ADDR_ERR_CNT, 16'h0000);
        for (i = 0; i < 260; i++) begin
            evt(1, 1'b0);
        end
        rd(RECP_ADDR_ERR_CNT, {8'h00, RECP_TALLY_MAX});
        rd(5'h1f, 16'h0000);
        for (i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            bus(1'b1, RECP_ADDR_PCS_CFG, seed[15:0] & 16'h0f00);
            @(negedge core_clk);
            chk(16'(cfg), 16'(seed[11:8]));
            rd(RECP_ADDR_PCS_CFG, seed[15:0] & 16'h0f00);
        end
        bus(1'b1, RECP_ADDR_PCS_CFG, 16'h0100);
        lk(1'b0, 1'b0, 1'b0, 1'b0);
        lk(1'b1, 1'b0, 1'b1, 1'b0);
        lk(1'b1, 1'b1, 1'b1, 1'b1);
        lk(1'b1, 1'b0, 1'b1, 1'b1);
        lk(1'b0, 1'b0, 1'b0, 1'b0);
        bus(1'b1, RECP_ADDR_PCS_CFG, 16'h0000);
        lk(1'b1, 1'b1, 1'b1, 1'b1);
        lk(1'b1, 1'b0, 1'b1, 1'b0);
        bus(1'b1, RECP_ADDR_PCS_CFG, 16'h0200);
        lk(1'b0, 1'b1, 1'b1, 1'b1);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        chk({14'h0000, signal_detect, link_up}, 16'h0000);
        rd(RECP_ADDR_PCS_CFG, {4'h0, RECP_PCS_RST, 8'h00});
        repeat (4) @(posedge core_clk);
        close_out();
    end
endmodule : tb_recp_regs
`default_nettype wire
